// [common/mdt_pkg.sv]
// Constants, field layout and timing for the drive tuning register block
// What this block does
// - PWM rate 20/30/40 kHz from rate field
// - Extension flag adds 200 ns to filters
// - Blank extension flag forces 4 us blanking
// - Comparator filtered for 0.5/1/2/3 us
// - Run decay field picks auto1/slow/mixed/auto2
// - Hold decay bit picks slow or mixed
// - Phase A freewheel bit picks high/low side
// - Phase B freewheel bit picks high/low side
// - Open-load wait bit picks 30 or 60 ms
// - Hold request selects hold versus run decay
`default_nettype none
package mdt_pkg;
  // Clock and register location
  localparam int unsigned CLK_MHZ      = 125;
  localparam logic [6:0]  ADDR_TUNING  = 7'h06;
  localparam logic [15:0] TUNING_RESET = 16'h0C00;
  localparam logic [15:0] TUNING_WMASK = 16'hFFFC;

  // Field positions
  localparam int PWM_HI_BIT   = 15;
  localparam int FEXT_BIT     = 13;
  localparam int BEXT_BIT     = 12;
  localparam int FILT_LSB     = 10;
  localparam int EDGE_LSB     = 8;
  localparam int RUN_LSB      = 6;
  localparam int FWA_BIT      = 5;
  localparam int FWB_BIT      = 4;
  localparam int OLW_BIT      = 3;
  localparam int HOLD_DEC_BIT = 2;

  typedef logic [12:0] mdt_pwm_cnt_t;
  typedef logic [8:0]  mdt_filt_t;
  typedef logic [9:0]  mdt_blank_t;
  typedef logic [22:0] mdt_ol_t;

  // PWM rates, periods rounded down
  localparam int unsigned PWM_20K_HZ  = 20000;
  localparam int unsigned PWM_30K_HZ  = 30000;
  localparam int unsigned PWM_40K_HZ  = 40000;
  localparam int unsigned PWM_20K_CYC = CLK_MHZ * 1000000 / PWM_20K_HZ;
  localparam int unsigned PWM_30K_CYC = CLK_MHZ * 1000000 / PWM_30K_HZ;
  localparam int unsigned PWM_40K_CYC = CLK_MHZ * 1000000 / PWM_40K_HZ;

  // Filter, blanking times in ns; least times round up
  localparam int unsigned FT0_NS   = 500;
  localparam int unsigned FT1_NS   = 1000;
  localparam int unsigned FT2_NS   = 2000;
  localparam int unsigned FT3_NS   = 3000;
  localparam int unsigned FEXT_NS  = 200;
  localparam int unsigned OC_NS    = 1000;
  localparam int unsigned BEXT_NS  = 4000;
  localparam int unsigned BSR0_NS  = 2000;
  localparam int unsigned BSR1_NS  = 1500;
  localparam int unsigned BSR2_NS  = 1000;
  localparam int unsigned BSR3_NS  = 1000;
  localparam mdt_filt_t FT0_CYC  =
    mdt_filt_t'((FT0_NS * CLK_MHZ + 999) / 1000);
  localparam mdt_filt_t FT1_CYC  =
    mdt_filt_t'((FT1_NS * CLK_MHZ + 999) / 1000);
  localparam mdt_filt_t FT2_CYC  =
    mdt_filt_t'((FT2_NS * CLK_MHZ + 999) / 1000);
  localparam mdt_filt_t FT3_CYC  =
    mdt_filt_t'((FT3_NS * CLK_MHZ + 999) / 1000);
  localparam mdt_filt_t FEXT_CYC =
    mdt_filt_t'((FEXT_NS * CLK_MHZ + 999) / 1000);
  localparam mdt_filt_t OC_CYC   =
    mdt_filt_t'((OC_NS * CLK_MHZ + 999) / 1000);
  localparam mdt_blank_t BEXT_CYC =
    mdt_blank_t'((BEXT_NS * CLK_MHZ + 999) / 1000);
  localparam mdt_blank_t BSR0_CYC =
    mdt_blank_t'((BSR0_NS * CLK_MHZ + 999) / 1000);
  localparam mdt_blank_t BSR1_CYC =
    mdt_blank_t'((BSR1_NS * CLK_MHZ + 999) / 1000);
  localparam mdt_blank_t BSR2_CYC =
    mdt_blank_t'((BSR2_NS * CLK_MHZ + 999) / 1000);
  localparam mdt_blank_t BSR3_CYC =
    mdt_blank_t'((BSR3_NS * CLK_MHZ + 999) / 1000);

  // Open-load wait in ms
  localparam int unsigned OL_SHORT_MS  = 30;
  localparam int unsigned OL_LONG_MS   = 60;
  localparam int unsigned OL_SHORT_CYC = OL_SHORT_MS * CLK_MHZ * 1000;
  localparam int unsigned OL_LONG_CYC  = OL_LONG_MS * CLK_MHZ * 1000;

  // Decay codes; run field encodes the same way
  localparam logic [1:0] DECAY_AUTO1 = 2'h0;
  localparam logic [1:0] DECAY_SLOW  = 2'h1;
  localparam logic [1:0] DECAY_MIXED = 2'h2;
  localparam logic [1:0] DECAY_AUTO2 = 2'h3;
endpackage
`default_nettype wire

// [design/mdt_tuning.sv]
// Drive tuning register and the timing logic it steers
`default_nettype none
module mdt_tuning #(
  parameter int unsigned PWM_20K_CYC  = mdt_pkg::PWM_20K_CYC,
  parameter int unsigned PWM_30K_CYC  = mdt_pkg::PWM_30K_CYC,
  parameter int unsigned OL_SHORT_CYC = mdt_pkg::OL_SHORT_CYC,
  parameter int unsigned OL_LONG_CYC  = mdt_pkg::OL_LONG_CYC
) (
  input  wire logic        clock,
  input  wire logic        nrst,
  input  wire logic        reg_wr,
  input  wire logic [6:0]  reg_addr,
  input  wire logic [15:0] reg_wdata,
  output logic      [15:0] reg_rdata,
  input  wire logic        hold_request,
  input  wire logic        comp_raw,
  input  wire logic        oc_raw,
  input  wire logic        open_load_raw,
  output logic             pwm_tick,
  output logic             comp_filtered,
  output logic             oc_filtered,
  output logic [9:0]       blanking_cycles,
  output logic [1:0]       edge_speed_sel,
  output logic             hold_active,
  output logic [1:0]       decay_mode,
  output logic             phase_a_low_side,
  output logic             phase_b_low_side,
  output logic             open_load_flag
);
  // Address decode, shared by read and write paths
  function automatic logic hit(input logic [6:0] a);
    return a == mdt_pkg::ADDR_TUNING;
  endfunction

  // Filter time decode
  function automatic mdt_pkg::mdt_filt_t ft_cyc(input logic [1:0] s);
    case (s)
      2'h0:    return mdt_pkg::FT0_CYC;
      2'h1:    return mdt_pkg::FT1_CYC;
      2'h2:    return mdt_pkg::FT2_CYC;
      default: return mdt_pkg::FT3_CYC;
    endcase
  endfunction

  logic [15:0] ctrl_reg, ctrl_next, rdata_reg, rdata_next;
  logic [1:0]  decay_reg, decay_next;
  logic        hold_reg, hold_next;
  mdt_pkg::mdt_blank_t blank_reg, blank_next;

  // Register file; parity and reserved bit read as zero
  always_comb begin
    ctrl_next = ctrl_reg;
    if (reg_wr && hit(reg_addr)) begin
      ctrl_next = reg_wdata & mdt_pkg::TUNING_WMASK;
    end
    rdata_next = hit(reg_addr) ? ctrl_reg : 16'h0000;
  end

  // Decay and blanking resolved one cycle after a setting moves
  always_comb begin
    hold_next = hold_request;
    if (hold_request) begin
      decay_next = ctrl_reg[mdt_pkg::HOLD_DEC_BIT]
                 ? mdt_pkg::DECAY_MIXED : mdt_pkg::DECAY_SLOW;
    end else begin
      decay_next = ctrl_reg[mdt_pkg::RUN_LSB +: 2];
    end
    if (ctrl_reg[mdt_pkg::BEXT_BIT]) begin
      blank_next = mdt_pkg::BEXT_CYC;
    end else begin
      case (ctrl_reg[mdt_pkg::EDGE_LSB +: 2])
        2'h0:    blank_next = mdt_pkg::BSR0_CYC;
        2'h1:    blank_next = mdt_pkg::BSR1_CYC;
        2'h2:    blank_next = mdt_pkg::BSR2_CYC;
        default: blank_next = mdt_pkg::BSR3_CYC;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      ctrl_reg  <= mdt_pkg::TUNING_RESET;
      rdata_reg <= 16'h0000;
      decay_reg <= mdt_pkg::DECAY_AUTO1;
      hold_reg  <= 1'b0;
      blank_reg <= mdt_pkg::BSR0_CYC;
    end else begin
      ctrl_reg  <= ctrl_next;
      rdata_reg <= rdata_next;
      decay_reg <= decay_next;
      hold_reg  <= hold_next;
      blank_reg <= blank_next;
    end
  end

  assign reg_rdata        = rdata_reg;
  assign decay_mode       = decay_reg;
  assign hold_active      = hold_reg;
  assign blanking_cycles  = blank_reg;
  assign edge_speed_sel   = ctrl_reg[mdt_pkg::EDGE_LSB +: 2];
  assign phase_a_low_side = ctrl_reg[mdt_pkg::FWA_BIT];
  assign phase_b_low_side = ctrl_reg[mdt_pkg::FWB_BIT];

  // PWM period counter; restarts when the rate changes
  logic [1:0] rate;
  mdt_pkg::mdt_pwm_cnt_t pwm_per, pwm_cnt_reg, pwm_cnt_next;
  logic [1:0] rate_reg;
  assign rate = ctrl_reg[mdt_pkg::PWM_HI_BIT -: 2];
  always_comb begin
    if (rate[1]) begin
      pwm_per = mdt_pkg::mdt_pwm_cnt_t'(mdt_pkg::PWM_40K_CYC);
    end else if (rate[0]) begin
      pwm_per = mdt_pkg::mdt_pwm_cnt_t'(PWM_30K_CYC);
    end else begin
      pwm_per = mdt_pkg::mdt_pwm_cnt_t'(PWM_20K_CYC);
    end
    pwm_cnt_next = pwm_cnt_reg + 13'h0001;
    if (rate != rate_reg || pwm_cnt_reg >= pwm_per - 13'h0001) begin
      pwm_cnt_next = 13'h0000;
    end
  end
  always_ff @(posedge clock) begin
    if (!nrst) begin
      pwm_cnt_reg <= 13'h0000;
      rate_reg    <= 2'h0;
    end else begin
      pwm_cnt_reg <= pwm_cnt_next;
      rate_reg    <= rate;
    end
  end
  assign pwm_tick = (rate == rate_reg) && (pwm_cnt_reg == pwm_per - 13'h0001);

  // Pin inputs: three-stage synchronisers, settled when 2nd and 3rd agree
  logic [2:0] raw_in;
  logic [2:0] sync_reg [3];
  logic [2:0] settled, level;
  assign raw_in = {open_load_raw, oc_raw, comp_raw};
  always_ff @(posedge clock) begin
    if (!nrst) begin
      for (int i = 0; i < 3; i++) sync_reg[i] <= 3'h0;
    end else begin
      sync_reg[0] <= raw_in;
      sync_reg[1] <= sync_reg[0];
      sync_reg[2] <= sync_reg[1];
    end
  end
  assign settled = ~(sync_reg[1] ^ sync_reg[2]);
  assign level   = sync_reg[2];

  // Comparator and overcurrent deglitch; a one-cycle glitch holds the count, a settled return clears it
  mdt_pkg::mdt_filt_t filt_lim [2];
  logic [1:0] filt_out;
  always_comb begin
    filt_lim[0] = ft_cyc(ctrl_reg[mdt_pkg::FILT_LSB +: 2]);
    filt_lim[1] = mdt_pkg::OC_CYC;
    if (ctrl_reg[mdt_pkg::FEXT_BIT]) begin
      filt_lim[0] = filt_lim[0] + mdt_pkg::FEXT_CYC;
      filt_lim[1] = filt_lim[1] + mdt_pkg::FEXT_CYC;
    end
  end
  for (genvar g = 0; g < 2; g++) begin : g_filt
    mdt_pkg::mdt_filt_t cnt_reg, cnt_next;
    logic out_reg, out_next;
    always_comb begin
      cnt_next = cnt_reg;
      out_next = out_reg;
      if (settled[g] && level[g] != out_reg) begin
        if (cnt_reg + 9'h001 >= filt_lim[g]) begin
          out_next = level[g];
          cnt_next = 9'h000;
        end else begin
          cnt_next = cnt_reg + 9'h001;
        end
      end else if (settled[g]) begin
        cnt_next = 9'h000;
      end
    end
    always_ff @(posedge clock) begin
      if (!nrst) begin
        cnt_reg <= 9'h000;
        out_reg <= 1'b0;
      end else begin
        cnt_reg <= cnt_next;
        out_reg <= out_next;
      end
    end
    assign filt_out[g] = out_reg;
  end
  assign comp_filtered = filt_out[0];
  assign oc_filtered   = filt_out[1];

  // Open-load qualification; a long wait trades speed for fewer false flags
  mdt_pkg::mdt_ol_t ol_lim, ol_cnt_reg, ol_cnt_next;
  logic ol_reg, ol_next;
  always_comb begin
    ol_lim = ctrl_reg[mdt_pkg::OLW_BIT]
           ? mdt_pkg::mdt_ol_t'(OL_LONG_CYC)
           : mdt_pkg::mdt_ol_t'(OL_SHORT_CYC);
    ol_cnt_next = ol_cnt_reg;
    ol_next     = ol_reg;
    if (settled[2] && !level[2]) begin
      ol_cnt_next = 23'h000000;
      ol_next     = 1'b0;
    end else if (settled[2] && !ol_reg) begin
      if (ol_cnt_reg + 23'h000001 >= ol_lim) begin
        ol_next = 1'b1;
      end else begin
        ol_cnt_next = ol_cnt_reg + 23'h000001;
      end
    end
  end
  always_ff @(posedge clock) begin
    if (!nrst) begin
      ol_cnt_reg <= 23'h000000;
      ol_reg     <= 1'b0;
    end else begin
      ol_cnt_reg <= ol_cnt_next;
      ol_reg     <= ol_next;
    end
  end
  assign open_load_flag = ol_reg;

  // Checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);
  a_pwm_fast_rate: assert property (
    rate[1] |-> pwm_per == 13'(mdt_pkg::PWM_40K_CYC))
    else $error("pwm period wrong for fast rate");
  a_pwm_tick_gap: assert property (
    pwm_tick && $stable(rate) |=> !pwm_tick)
    else $error("pwm ticks back to back");
  a_filter_extend: assert property (
    ctrl_reg[mdt_pkg::FEXT_BIT] |->
    filt_lim[1] == mdt_pkg::OC_CYC + mdt_pkg::FEXT_CYC)
    else $error("overcurrent filter not extended");
  a_blank_extend: assert property (
    ctrl_reg[mdt_pkg::BEXT_BIT] |=> blanking_cycles == mdt_pkg::BEXT_CYC)
    else $error("blanking not forced long");
  a_filter_wait: assert property (
    $changed(comp_filtered) |->
    $past(g_filt[0].cnt_reg) + 9'h001 >= $past(filt_lim[0]))
    else $error("comparator output changed too early");
  // Written field must reach the slew output on the next cycle
  a_edge_speed: assert property (
    reg_wr && hit(reg_addr) |=>
    edge_speed_sel == $past(reg_wdata[mdt_pkg::EDGE_LSB +: 2]))
    else $error("edge speed not from field");
  a_run_decay: assert property (
    !hold_request |=>
    decay_mode == $past(ctrl_reg[mdt_pkg::RUN_LSB +: 2]))
    else $error("run decay mismatch");
  a_hold_decay: assert property (
    hold_request && ctrl_reg[mdt_pkg::HOLD_DEC_BIT] |=>
    hold_active && decay_mode == mdt_pkg::DECAY_MIXED)
    else $error("hold decay not mixed");
  a_freewheel_a: assert property (
    reg_wr && hit(reg_addr) |=>
    phase_a_low_side == $past(reg_wdata[mdt_pkg::FWA_BIT]))
    else $error("phase a side wrong");
  a_freewheel_b: assert property (
    reg_wr && hit(reg_addr) |=>
    phase_b_low_side == $past(reg_wdata[mdt_pkg::FWB_BIT]))
    else $error("phase b side wrong");
  a_open_load_wait: assert property (
    $rose(open_load_flag) |->
    $past(ol_cnt_reg) + 23'h000001 >= $past(ol_lim))
    else $error("open load flagged early");
  a_reset_value: assert property (
    $past(!nrst) |->
    ctrl_reg == mdt_pkg::TUNING_RESET && reg_rdata == 16'h0000)
    else $error("reset value wrong");
  c_fast_tick: cover property (rate[1] && pwm_tick);
  c_hold_entry: cover property ($rose(hold_active));
  c_comp_rise: cover property ($rose(comp_filtered));
  c_open_load: cover property ($rose(open_load_flag));
endmodule
`default_nettype wire

// [design/unused_placeholder_none.sv]
// Intentionally empty design unit list
`default_nettype none
`default_nettype wire

// [tb/mdt_host.sv]
// Host-side register access model for the drive tuning block
`default_nettype none
module mdt_host (
  input  wire logic        clock,
  output logic             reg_wr,
  output logic [6:0]       reg_addr,
  output logic [15:0]      reg_wdata,
  input  wire logic [15:0] reg_rdata
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    reg_wr = 1'b0;
    reg_addr = 7'h00;
    reg_wdata = 16'h0000;
  end
  // One-cycle strobe; data inverted after so stale bits never look valid
  task automatic wr(input logic [6:0] a, input logic [15:0] d);
    @(posedge clock);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clock);
    reg_wr <= 1'b0;
    reg_wdata <= ~d;
  endtask
  // Read data is registered, so take it one edge after the address
  task automatic rd(input logic [6:0] a, output logic [15:0] d);
    @(posedge clock);
    reg_addr <= a;
    @(posedge clock);
    #1;
    d = reg_rdata;
  endtask
endmodule
`default_nettype wire

// [tb/motor_drive_tuning_register_tb.sv]
// Self-checking bench for the drive tuning register block
`default_nettype none
module motor_drive_tuning_register_tb;
  timeunit 1ns;
  timeprecision 1ns;
  // Short counts keep the run small
  localparam int P20 = 200, P30 = 150, OLS = 100, OLL = 200;
  logic        clock, nrst, hold_request, comp_raw, oc_raw, open_load_raw;
  logic        reg_wr, pwm_tick, comp_filtered, oc_filtered, hold_active;
  logic        phase_a_low_side, phase_b_low_side, open_load_flag;
  logic [6:0]  reg_addr;
  logic [15:0] reg_wdata, reg_rdata, v;
  logic [9:0]  blanking_cycles;
  logic [1:0]  edge_speed_sel, decay_mode;
  integer      seed = 76921, n_fail = 0, check_count = 0, cyc = 0;
  int          model, n, nc, no, nl, lc, lo, ll;

  mdt_host host (.clock(clock), .reg_wr(reg_wr), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));
  mdt_tuning #(.PWM_20K_CYC(P20), .PWM_30K_CYC(P30), .OL_SHORT_CYC(OLS),
    .OL_LONG_CYC(OLL)) dut (.clock(clock), .nrst(nrst), .reg_wr(reg_wr),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .hold_request(hold_request), .comp_raw(comp_raw), .oc_raw(oc_raw),
    .open_load_raw(open_load_raw), .pwm_tick(pwm_tick),
    .comp_filtered(comp_filtered), .oc_filtered(oc_filtered),
    .blanking_cycles(blanking_cycles), .edge_speed_sel(edge_speed_sel),
    .hold_active(hold_active), .decay_mode(decay_mode),
    .phase_a_low_side(phase_a_low_side),
    .phase_b_low_side(phase_b_low_side), .open_load_flag(open_load_flag));

  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  // Hang guard, well above the expected 25k cycles
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      n_fail = n_fail + 1;
      summarize();
    end
  end

  task automatic summarize();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] e,
                     input logic [15:0] g);
    check_count++;
    if (g !== e) begin
      n_fail++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Write through the host and mirror it in the model
  task automatic put(input logic [6:0] a, input logic [15:0] d);
    host.wr(a, d);
    if (a == 7'h06) model = d & 16'hFFFC;
  endtask
  // Readback plus every static output derived from the register
  task automatic check_all();
    int bl;
    int dm;
    bl = model[12] ? 500 : model[9:8] == 0 ? 250 : model[9:8] == 1 ? 188 : 125;
    dm = hold_request ? (model[2] ? 2 : 1) : model[7:6];
    host.rd(7'h06, v);
    chk("rdata", model[15:0], v);
    chk("edge_speed", model[9:8], edge_speed_sel);
    chk("phase_a", model[5], phase_a_low_side);
    chk("phase_b", model[4], phase_b_low_side);
    chk("blanking", bl, blanking_cycles);
    chk("hold_active", hold_request, hold_active);
    chk("decay", dm, decay_mode);
  endtask
  // Cycles until the next tick, bounded
  task automatic gap(output int k);
    k = 0;
    do begin
      @(posedge clock);
      #1;
      k++;
    end while (pwm_tick !== 1'b1 && k < 4000);
  endtask
  // Drive all three sensed pins and time each filtered response
  task automatic pins(input logic lv);
    @(posedge clock);
    comp_raw <= lv;
    oc_raw <= lv;
    open_load_raw <= lv;
    nc = 0;
    no = 0;
    nl = 0;
    for (int k = 1; k <= 700; k++) begin
      @(posedge clock);
      #1;
      if (nc == 0 && comp_filtered === lv) nc = k;
      if (no == 0 && oc_filtered === lv) no = k;
      if (nl == 0 && open_load_flag === lv) nl = k;
    end
  endtask

  initial begin
    nrst = 1'b0;
    hold_request = 1'b0;
    comp_raw = 1'b0;
    oc_raw = 1'b0;
    open_load_raw = 1'b0;
    model = 16'h0C00;
    repeat (12) @(posedge clock);
    nrst <= 1'b1;
    check_all();
    $display("reset test done");
    // Random contents, hold toggling, every eighth write unmapped
    for (int i = 0; i < 40; i++) begin
      @(posedge clock);
      hold_request <= $random(seed);
      put((i % 8 == 7) ? 7'h05 : 7'h06, $random(seed));
      check_all();
    end
    host.rd(7'h05, v);
    chk("unmapped", 16'h0000, v);
    $display("register test done");
    // All four rate codes, period between two ticks
    for (int r = 0; r < 4; r++) begin
      put(7'h06, {r[1:0], 14'h0} | (model & 16'h3FFF));
      gap(n);
      gap(n);
      lc = r == 0 ? P20 : r == 1 ? P30 : mdt_pkg::PWM_40K_CYC;
      chk("pwm_period", 16'(lc), 16'(n));
    end
    $display("pwm test done");
    // Filter codes with and without extension, open-load wait both ways
    for (int f = 0; f < 8; f++) begin
      put(7'h06, (model & 16'hD3F7) | (f[1:0] << 10) | (f[2] << 13)
        | (f[0] << 3));
      lc = (f % 4 == 0 ? 63 : f % 4 == 1 ? 125 : f % 4 == 2 ? 250 : 375)
        + 25 * f[2];
      lo = 125 + 25 * f[2];
      ll = f[0] ? OLL : OLS;
      pins(1'b1);
      chk("comp_delay", 1, nc >= lc && nc <= lc + 6);
      chk("oc_delay", 1, no >= lo && no <= lo + 6);
      chk("ol_delay", 1, nl >= ll && nl <= ll + 6);
      pins(1'b0);
      chk("pins_low", 0, {comp_filtered, oc_filtered, open_load_flag});
    end
    $display("filter test done");
    summarize();
  end
endmodule
`default_nettype wire
